//--- sim/boot_eprom_model.sv
// Purpose: byte-wide boot memory answering the loader's reads
// Assumes: byte at offset k holds a pattern of k
// Notes:   idle data bus toggles so a stale byte never matches
`timescale 1ns/10ps
module boot_eprom_model #(
    parameter int WAIT_CYCLES = 2
) (
    input  wire logic        clk_in,
    input  wire logic        rd_in,
    input  wire logic        cs_n_in,
    input  wire logic [23:0] addr_in,
    output logic             ack_out,
    output logic [7:0]       data_out
);
    int          cnt = 0;
    logic [23:0] ofs;
    assign ofs = addr_in - 24'h800000;
    initial begin
        ack_out = 1'b0;
        data_out = 8'h00;
    end
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        data_out <= ~data_out;
        if (rd_in && !cs_n_in && !ack_out) begin
            cnt <= cnt + 1;
            if (cnt == WAIT_CYCLES) begin
                ack_out <= 1'b1;
                data_out <= ofs[7:0] ^ {5'h0, ofs[10:8]} ^ 8'h5a;
                cnt <= 0;
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule : boot_eprom_model

//--- sim/boot_mode_select_loader_test.sv
// Purpose: self-checking bench of the boot mode select loader
// Assumes: same byte pattern from every source, 8- and 16-bit host words
// Notes:   mem side has no stall input, so the fifo is never driven full
`timescale 1ns/10ps
module boot_mode_select_loader_test;
    logic        sys_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        eprom_sel = 1'b0, link_sel = 1'b0, strap_bms = 1'b1, bus_master = 1'b1;
    logic        bms_out, bms_oe, bms_wire, ext_rd, ext_ack, mem_we, irq, vec, ext_run;
    logic        host_ready, link_ready, spi_ready;
    logic        host_wide = 1'b1;
    logic [2:0]  vld = 3'h0, ready_q = 3'h0, rdy, boot_mode;
    logic [23:0] ext_addr;
    logic [7:0]  ext_data, spi_data = 8'h00;
    logic [15:0] host_data = 16'h0000;
    logic [3:0]  link_data = 4'h0;
    logic [19:0] mem_addr, vector_addr;
    logic [47:0] mem_data;
    int          wcount = 0, irqs = 0, vecs = 0, mismatches = 0, tests_run = 0;

    assign bms_wire = bms_oe ? bms_out : strap_bms;
    assign rdy = {spi_ready, link_ready, host_ready};

    boot_mode_select_loader boot_mode_select_loader_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .eprom_boot_sel_in(eprom_sel),
        .link_boot_sel_in(link_sel), .boot_mem_select_in(bms_wire),
        .boot_mem_select_out(bms_out), .boot_mem_select_oe_out(bms_oe),
        .bus_master_in(bus_master), .ext_addr_out(ext_addr), .ext_rd_out(ext_rd),
        .ext_ack_in(ext_ack), .ext_data_in(ext_data), .host_valid_in(vld[0]),
        .host_wide_in(host_wide), .host_data_in(host_data), .host_ready_out(host_ready),
        .link_valid_in(vld[1]), .link_data_in(link_data), .link_ready_out(link_ready),
        .spi_valid_in(vld[2]), .serial_rx_buffer_in(spi_data), .spi_ready_out(spi_ready),
        .mem_we_out(mem_we), .mem_addr_out(mem_addr), .mem_data_out(mem_data),
        .boot_irq_out(irq), .vector_out(vec), .vector_addr_out(vector_addr),
        .ext_run_out(ext_run), .boot_mode_out(boot_mode));

    boot_eprom_model boot_eprom_model_i (
        .clk_in(sys_clk_in), .rd_in(ext_rd), .cs_n_in(bms_wire), .addr_in(ext_addr),
        .ack_out(ext_ack), .data_out(ext_data));

    initial begin
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    function automatic logic [7:0] pat(input int k);
        return k[7:0] ^ {5'h0, k[10:8]} ^ 8'h5a;
    endfunction : pat

    function automatic logic [47:0] word_of(input int w);
        logic [47:0] r;
        // a narrow host leaves the upper byte of each halfword at zero
        for (int m = 0; m < 6; m++) r[8*m +: 8] = (!host_wide && m[0]) ? 8'h00 : pat(6*w + m);
        return r;
    endfunction : word_of

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done();
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    // pre-edge ready, so a take is judged on what the design sampled
    always @(posedge sys_clk_in) ready_q <= rdy;

    always @(negedge sys_clk_in) begin
        if (rst_in) begin
            wcount = 0;
            irqs = 0;
            vecs = 0;
        end else begin
            if (mem_we === 1'b1) begin
                check("mem_addr", 48'(mem_addr), 48'(20'h40000 + wcount));
                check("mem_data", mem_data, word_of(wcount));
                wcount++;
            end
            if (irq === 1'b1) irqs++;
            if (vec === 1'b1) vecs++;
        end
    end

    task automatic do_reset(input logic e, input logic l, input logic b);
        @(negedge sys_clk_in);
        rst_in = 1'b1;
        eprom_sel = e;
        link_sel = l;
        strap_bms = b;
        repeat (10) @(negedge sys_clk_in);
        rst_in = 1'b0;
    endtask : do_reset

    // one piece per take, a free cycle after each to keep the spacing
    task automatic feed(input int sel, input int pieces);
        int         i;
        logic [7:0] b;
        i = 0;
        while (i < pieces) begin
            @(negedge sys_clk_in);
            if (vld[sel] && ready_q[sel]) begin
                vld[sel] = 1'b0;
                i++;
            end else if (!vld[sel] && rdy[sel]) begin
                b = pat(i / 2);
                host_data = {pat(2*i + 1), pat(2*i)};
                link_data = i[0] ? b[7:4] : b[3:0];
                spi_data = pat(i);
                vld[sel] = 1'b1;
            end
        end
    endtask : feed

    task automatic expect_end(input logic [2:0] mode);
        for (int n = 0; n < 20000 && irqs == 0; n++) @(negedge sys_clk_in);
        repeat (10) @(negedge sys_clk_in);
        check("boot_mode", 48'(boot_mode), 48'(mode));
        check("words", 48'(wcount), 48'h100);
        check("irq_pulses", 48'(irqs), 48'h1);
        check("vector_pulses", 48'(vecs), 48'h1);
        check("vector_addr", 48'(vector_addr), 48'h40050);
        check("select_oe", 48'(bms_oe), 48'h0);
    endtask : expect_end

    task automatic scen_eprom();
        bus_master = 1'b0;
        do_reset(1'b1, 1'b0, 1'b1);
        repeat (40) @(negedge sys_clk_in);
        check("oe_not_master", 48'(bms_oe), 48'h0);
        check("words_not_master", 48'(wcount), 48'h0);
        bus_master = 1'b1;
        repeat (200) @(negedge sys_clk_in);
        check("oe_master", 48'(bms_oe), 48'h1);
        check("select_low", 48'(bms_out), 48'h0);
        eprom_sel = 1'b0;
        link_sel = 1'b1;
        expect_end(boot_loader_pkg::MODE_EPROM);
    endtask : scen_eprom

    task automatic scen_host();
        host_wide = 1'b1;
        do_reset(1'b0, 1'b0, 1'b1);
        feed(0, 768);
        expect_end(boot_loader_pkg::MODE_HOST);
        host_wide = 1'b0;
        do_reset(1'b0, 1'b0, 1'b1);
        feed(0, 768);
        expect_end(boot_loader_pkg::MODE_HOST);
        host_wide = 1'b1;
    endtask : scen_host

    task automatic scen_link();
        do_reset(1'b0, 1'b1, 1'b1);
        feed(1, 3072);
        expect_end(boot_loader_pkg::MODE_LINK);
    endtask : scen_link

    task automatic scen_spi();
        do_reset(1'b0, 1'b1, 1'b0);
        feed(2, 1536);
        expect_end(boot_loader_pkg::MODE_SPI);
    endtask : scen_spi

    task automatic scen_noboot();
        do_reset(1'b0, 1'b0, 1'b0);
        repeat (300) @(negedge sys_clk_in);
        check("noboot_mode", 48'(boot_mode), 48'(boot_loader_pkg::MODE_NOBOOT));
        check("ext_run", 48'(ext_run), 48'h1);
        check("noboot_words", 48'(wcount), 48'h0);
        check("noboot_irq", 48'(irqs), 48'h0);
    endtask : scen_noboot

    initial begin
        repeat (60000) @(posedge sys_clk_in);
        mismatches++;
        test_done();
    end

    initial begin
        scen_eprom();
        scen_host();
        scen_link();
        scen_spi();
        scen_noboot();
        test_done();
    end
endmodule : boot_mode_select_loader_test

//--- verilog/boot_loader_cfg.svh
// Purpose: constants of the boot mode select loader
// Assumes: 40 MHz core clock
// Notes:   word counts and addresses of the boot load
`ifndef BOOT_LOADER_CFG_SVH
`define BOOT_LOADER_CFG_SVH
`define KERNEL_WORDS      9'h100
`define EPROM_BYTES_WORD  3'h6
`define HOST_HALVES_WORD  3'h3
`define LINK_NIBS_WORD    4'hc
`define SPI_BYTES_WORD    3'h6
`define KERNEL_BASE       20'h40000
`define IRQ_VECTOR        20'h40050
`define EPROM_BASE        24'h800000
`define FIFO_DEPTH        32
`define FIFO_AW           5
`endif

//--- verilog/boot_loader_pkg.sv
// Purpose: types of the boot mode select loader
// Assumes: nothing
// Notes:   source channels follow the decoded mode
package boot_loader_pkg;
    typedef enum logic [2:0] {
        MODE_EPROM,
        MODE_HOST,
        MODE_LINK,
        MODE_SPI,
        MODE_NOBOOT
    } boot_mode_t;
    typedef enum logic [2:0] {
        ST_STRAP,
        ST_LOAD,
        ST_DRAIN,
        ST_DONE,
        ST_EXT_RUN
    } load_state_t;
endpackage : boot_loader_pkg

//--- verilog/boot_mode_select_loader.sv
// Purpose: power-up boot mode decode and 256-word kernel load
// Assumes: straps and stream inputs synchronous to sys_clk_in
// Notes:   one fifo of 48-bit words between packer and memory writer
// Function
// - decode eprom, host, link, spi or no-boot from three strap pins
// - eprom mode packs bytes from an 8-bit wide external memory
// - eprom mode drives boot_mem_select as the memory chip select
// - only the current bus master drives boot_mem_select
// - host mode accepts 8- or 16-bit words from the host
// - link mode collects 4-bit nibbles into link receive buffer 4
// - spi mode moves serial_rx_buffer bytes to memory by channel 8
// - no-boot mode loads nothing and runs from external memory
// - after reset arm the mode's channel for 256 instruction words
// - at zero counts stop, interrupt, release select, vector
`timescale 1ns/10ps
`include "boot_loader_cfg.svh"
module boot_mode_select_loader (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        eprom_boot_sel_in,
    input  wire logic        link_boot_sel_in,
    input  wire logic        boot_mem_select_in,
    output logic             boot_mem_select_out,
    output logic             boot_mem_select_oe_out,
    input  wire logic        bus_master_in,
    output logic [23:0]      ext_addr_out,
    output logic             ext_rd_out,
    input  wire logic        ext_ack_in,
    input  wire logic [7:0]  ext_data_in,
    input  wire logic        host_valid_in,
    input  wire logic        host_wide_in,
    input  wire logic [15:0] host_data_in,
    output logic             host_ready_out,
    input  wire logic        link_valid_in,
    input  wire logic [3:0]  link_data_in,
    output logic             link_ready_out,
    input  wire logic        spi_valid_in,
    input  wire logic [7:0]  serial_rx_buffer_in,
    output logic             spi_ready_out,
    output logic             mem_we_out,
    output logic [19:0]      mem_addr_out,
    output logic [47:0]      mem_data_out,
    output logic             boot_irq_out,
    output logic             vector_out,
    output logic [19:0]      vector_addr_out,
    output logic             ext_run_out,
    output logic [2:0]       boot_mode_out
);
    boot_loader_pkg::boot_mode_t  mode_r, mode_nxt;
    boot_loader_pkg::load_state_t st_r, st_nxt;
    logic [47:0] pack_r, pack_nxt;
    logic [3:0]  part_r, part_nxt;
    logic [8:0]  icnt_r, icnt_nxt;
    logic [11:0] ecnt_r, ecnt_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic        rd_r, rd_nxt, sel_r, sel_nxt, oe_r, oe_nxt;
    logic        we_r, we_nxt, irq_r, irq_nxt, run_r, run_nxt;
    logic [19:0] maddr_r, maddr_nxt;
    logic [47:0] mdata_r, mdata_nxt;
    logic        hrdy_r, hrdy_nxt, lrdy_r, lrdy_nxt, srdy_r, srdy_nxt;
    logic        f_valid, f_ready, o_valid, o_ready;
    logic [47:0] f_data, o_data;
    logic [3:0]  parts;
    logic        take;

    word_fifo #(.WIDTH(48), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) word_fifo_i (
        .clk_in       (sys_clk_in),
        .rst_in       (rst_in),
        .wr_data_in   (f_data),
        .wr_valid_in  (f_valid),
        .wr_ready_out (f_ready),
        .rd_data_out  (o_data),
        .rd_valid_out (o_valid),
        .rd_ready_in  (o_ready)
    );

    always_comb begin
        mode_nxt = mode_r;
        st_nxt   = st_r;
        pack_nxt = pack_r;
        part_nxt = part_r;
        icnt_nxt = icnt_r;
        ecnt_nxt = ecnt_r;
        addr_nxt = addr_r;
        rd_nxt   = 1'b0;
        sel_nxt  = 1'b1;
        oe_nxt   = 1'b0;
        we_nxt   = 1'b0;
        irq_nxt  = 1'b0;
        run_nxt  = run_r;
        maddr_nxt = maddr_r;
        mdata_nxt = mdata_r;
        hrdy_nxt = 1'b0;
        lrdy_nxt = 1'b0;
        srdy_nxt = 1'b0;
        take     = 1'b0;
        f_valid  = 1'b0;
        f_data   = pack_r;
        o_ready  = 1'b0;
        unique case (mode_r)
            boot_loader_pkg::MODE_EPROM: parts = 4'(`EPROM_BYTES_WORD);
            boot_loader_pkg::MODE_HOST:  parts = 4'(`HOST_HALVES_WORD);
            boot_loader_pkg::MODE_LINK:  parts = `LINK_NIBS_WORD;
            default:                     parts = 4'(`SPI_BYTES_WORD);
        endcase
        unique case (st_r)
            boot_loader_pkg::ST_STRAP: begin
                // first cycle after release: straps are now stable
                if (eprom_boot_sel_in) mode_nxt = boot_loader_pkg::MODE_EPROM;
                else if (!link_boot_sel_in && boot_mem_select_in)
                    mode_nxt = boot_loader_pkg::MODE_HOST;
                else if (link_boot_sel_in && boot_mem_select_in)
                    mode_nxt = boot_loader_pkg::MODE_LINK;
                else if (link_boot_sel_in)
                    mode_nxt = boot_loader_pkg::MODE_SPI;
                else mode_nxt = boot_loader_pkg::MODE_NOBOOT;
                icnt_nxt  = `KERNEL_WORDS;
                ecnt_nxt  = 12'(`KERNEL_WORDS) * 12'(`EPROM_BYTES_WORD);
                addr_nxt  = `EPROM_BASE;
                maddr_nxt = `KERNEL_BASE;
                part_nxt  = '0;
                st_nxt = (mode_nxt == boot_loader_pkg::MODE_NOBOOT)
                         ? boot_loader_pkg::ST_EXT_RUN : boot_loader_pkg::ST_LOAD;
            end
            boot_loader_pkg::ST_LOAD: begin
                if (part_r == parts) begin
                    f_valid = 1'b1;
                    if (f_ready) begin
                        part_nxt = '0;
                        pack_nxt = '0;
                        if (icnt_r == 9'h001) st_nxt = boot_loader_pkg::ST_DRAIN;
                        icnt_nxt = icnt_r - 9'h001;
                    end
                end else begin
                    unique case (mode_r)
                        boot_loader_pkg::MODE_EPROM: begin
                            // select held only while this device masters the bus
                            oe_nxt  = bus_master_in;
                            sel_nxt = 1'b0;
                            rd_nxt  = bus_master_in && !(rd_r && ext_ack_in);
                            if (rd_r && ext_ack_in) begin
                                take     = 1'b1;
                                pack_nxt = {ext_data_in, pack_r[47:8]};
                                addr_nxt = addr_r + 24'h000001;
                                ecnt_nxt = ecnt_r - 12'h001;
                            end
                        end
                        boot_loader_pkg::MODE_HOST: begin
                            hrdy_nxt = !(hrdy_r && host_valid_in);
                            if (hrdy_r && host_valid_in) begin
                                take = 1'b1;
                                // 8-bit hosts fill the low byte, upper zero
                                pack_nxt = {host_wide_in ? host_data_in
                                            : {8'h00, host_data_in[7:0]},
                                            pack_r[47:16]};
                            end
                        end
                        boot_loader_pkg::MODE_LINK: begin
                            lrdy_nxt = !(lrdy_r && link_valid_in);
                            if (lrdy_r && link_valid_in) begin
                                take = 1'b1;
                                pack_nxt = {link_data_in, pack_r[47:4]};
                            end
                        end
                        default: begin
                            srdy_nxt = !(srdy_r && spi_valid_in);
                            if (srdy_r && spi_valid_in) begin
                                take = 1'b1;
                                pack_nxt = {serial_rx_buffer_in, pack_r[47:8]};
                            end
                        end
                    endcase
                    if (take) part_nxt = part_r + 4'h1;
                end
            end
            boot_loader_pkg::ST_DRAIN: begin
                if (!o_valid && !we_r) begin
                    irq_nxt = 1'b1;
                    st_nxt  = boot_loader_pkg::ST_DONE;
                end
            end
            boot_loader_pkg::ST_DONE: begin
            end
            boot_loader_pkg::ST_EXT_RUN: begin
                run_nxt = 1'b1;
            end
            default: st_nxt = boot_loader_pkg::ST_STRAP;
        endcase
        // memory writer drains the fifo one word per cycle
        o_ready = o_valid;
        if (o_valid) begin
            we_nxt    = 1'b1;
            mdata_nxt = o_data;
        end
        if (we_r) maddr_nxt = maddr_r + 20'h00001;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            mode_r <= boot_loader_pkg::MODE_NOBOOT;
            st_r   <= boot_loader_pkg::ST_STRAP;
            pack_r <= '0;
            part_r <= '0;
            icnt_r <= '0;
            ecnt_r <= '0;
            addr_r <= '0;
            rd_r   <= 1'b0;
            sel_r  <= 1'b1;
            oe_r   <= 1'b0;
            we_r   <= 1'b0;
            irq_r  <= 1'b0;
            run_r  <= 1'b0;
            maddr_r <= '0;
            mdata_r <= '0;
            hrdy_r <= 1'b0;
            lrdy_r <= 1'b0;
            srdy_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            st_r   <= st_nxt;
            pack_r <= pack_nxt;
            part_r <= part_nxt;
            icnt_r <= icnt_nxt;
            ecnt_r <= ecnt_nxt;
            addr_r <= addr_nxt;
            rd_r   <= rd_nxt;
            sel_r  <= sel_nxt;
            oe_r   <= oe_nxt;
            we_r   <= we_nxt;
            irq_r  <= irq_nxt;
            run_r  <= run_nxt;
            maddr_r <= maddr_nxt;
            mdata_r <= mdata_nxt;
            hrdy_r <= hrdy_nxt;
            lrdy_r <= lrdy_nxt;
            srdy_r <= srdy_nxt;
        end
    end

    assign boot_mem_select_out    = sel_r;
    assign boot_mem_select_oe_out = oe_r;
    assign ext_addr_out    = addr_r;
    assign ext_rd_out      = rd_r;
    assign host_ready_out  = hrdy_r;
    assign link_ready_out  = lrdy_r;
    assign spi_ready_out   = srdy_r;
    assign mem_we_out      = we_r;
    assign mem_addr_out    = maddr_r;
    assign mem_data_out    = mdata_r;
    assign boot_irq_out    = irq_r;
    assign vector_out      = irq_r;
    assign vector_addr_out = `IRQ_VECTOR;
    assign ext_run_out     = run_r;
    assign boot_mode_out   = mode_r;

    a_eprom_mode_decode: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        st_r == boot_loader_pkg::ST_STRAP && eprom_boot_sel_in
        |=> mode_r == boot_loader_pkg::MODE_EPROM)
        else $error("eprom strap not decoded");
    a_nonboot_decode: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        st_r == boot_loader_pkg::ST_STRAP && !eprom_boot_sel_in && !link_boot_sel_in
        && !boot_mem_select_in |=> ##1 ext_run_out)
        else $error("no-boot strap not decoded");
    a_select_eprom_only: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        boot_mem_select_oe_out |-> mode_r == boot_loader_pkg::MODE_EPROM && !sel_r)
        else $error("select driven outside eprom load");
    a_select_master_only: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        boot_mem_select_oe_out |-> $past(bus_master_in))
        else $error("select driven without mastership");
    a_mode_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        st_r != boot_loader_pkg::ST_STRAP |=> $stable(mode_r))
        else $error("boot mode changed after reset");
    a_nine_no_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        mode_r == boot_loader_pkg::MODE_NOBOOT |-> !mem_we_out && !ext_rd_out)
        else $error("no-boot mode loaded data");
    a_count_armed: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        st_r == boot_loader_pkg::ST_STRAP |=> icnt_r == 9'h100 && ecnt_r == 12'h600)
        else $error("boot counts not armed");
    a_done_vector: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $rose(boot_irq_out) |-> icnt_r == 9'h000
        && maddr_r == 20'h40100 && !boot_mem_select_oe_out)
        else $error("boot end without full load");
endmodule : boot_mode_select_loader

//--- verilog/word_fifo.sv
// Purpose: small synchronous fifo with valid and ready on both sides
// Assumes: single clock, synchronous reset
// Notes:   full and empty are exact, no bypass
`timescale 1ns/10ps
module word_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    logic [AW:0]      wp_nxt;
    logic [AW:0]      rp_nxt;
    logic             push;
    logic             pop;

    always_comb begin
        wr_ready_out = (wp_r - rp_r) != (AW+1)'(DEPTH);
        rd_valid_out = wp_r != rp_r;
        rd_data_out  = mem[rp_r[AW-1:0]];
        push         = wr_valid_in && wr_ready_out;
        pop          = rd_valid_out && rd_ready_in;
        wp_nxt       = push ? wp_r + 1'b1 : wp_r;
        rp_nxt       = pop ? rp_r + 1'b1 : rp_r;
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= wr_data_in;
        end
        if (rst_in) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end
endmodule : word_fifo
